// >>> logic/sup_dev_end.sv
// supervisor device end: configuration register and write protection
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sup_dev_end #(
  parameter int NV_CYCLES = sup_pkg::NV_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // two-wire link
  sup_link_if.dev link,
  // protect pin and programming-level detector
  input wire logic wp_pin,
  input wire logic wp_prog_level,
  // stored settings
  input wire logic [sup_pkg::NV_W-1:0] nv_image,
  output logic nv_store,
  output logic [sup_pkg::NV_W-1:0] nv_word,
  // memory array
  output logic arr_wr_en,
  output logic [sup_pkg::ARR_AW-1:0] arr_wr_addr,
  output logic [7:0] arr_wr_data,
  output logic [sup_pkg::ARR_AW-1:0] arr_rd_addr,
  input wire logic [7:0] arr_rd_data,
  // settings and status
  output logic [1:0] dog_period_sel,
  output logic dog_enable,
  output logic [10:0] dog_timeout_ms,
  output logic [2:0] lock_sel,
  output logic hw_protect,
  output logic nv_busy,
  output logic vtrip_prog
);
  import sup_pkg::*;
  localparam int BW = $clog2(NV_CYCLES + 1);
  typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK} supd_st_t;
  supd_st_t dst_r;
  logic [3:0] bitc_r;
  logic [2:0] bidx_r;
  logic [7:0] shift_r, tx_r, rx_data_r;
  logic [15:0] ptr_r;
  logic drive_r, rd_mode_r, pend_reg_r, abort_r, pend_vt_r, arr_done_r;
  logic write_latch, reg_write_unlock, hw_protect_arm, boot_r;
  logic [1:0] dog_r;
  logic [2:0] lock_r;
  logic [BW-1:0] busy_r;
  logic scl_s, sda_s, wp_s, prog_s, scl_p, sda_p;
  logic rise, fall, start_ev, stop_ev, is_cfg, lock_hit, busy, byte_end;
  logic adr_ack, cfg_ok, vt_ok, arr_ok, data_ack, ack_now;
  logic nv_wr, lock_refuse, cfg_end;
  logic [7:0] cfg_byte, tx_sel;

  function automatic logic lock_fn(input logic [13:0] a,
    input logic [2:0] c);
    case (c)
      LK_Q4: lock_fn = a >= Q4_BASE;
      LK_HALF: lock_fn = a >= HALF_BASE;
      LK_ALL: lock_fn = 1'b1;
      LK_P1: lock_fn = a <= P1_TOP;
      LK_P2: lock_fn = a <= P2_TOP;
      LK_P4: lock_fn = a <= P4_TOP;
      LK_P8: lock_fn = a <= P8_TOP;
      default: lock_fn = 1'b0;
    endcase
  endfunction

  sup_sync2 #(.W(4)) u_sync (.clk(clk), .sys_rst(sys_rst),
    .async_in({link.scl, link.sda, wp_pin, wp_prog_level}),
    .sync_out({scl_s, sda_s, wp_s, prog_s}));

  ////////////////////////////////////////////////////////////////////////
  // link events and decisions
  assign rise = scl_s & ~scl_p;
  assign fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;
  assign is_cfg = ptr_r == CFG_ADDR;
  assign busy = busy_r != '0;
  assign hw_protect = wp_s & hw_protect_arm;
  assign lock_hit = lock_fn(ptr_r[13:0], lock_r);
  assign cfg_byte = {hw_protect_arm, dog_r, lock_r[1:0], reg_write_unlock,
    write_latch, lock_r[2]};
  assign tx_sel = is_cfg ? cfg_byte : arr_rd_data;
  assign byte_end = fall && dst_r == D_RECV && bitc_r == BYTE_BITS &&
    !start_ev && !stop_ev;
  assign adr_ack = shift_r[7:1] == DEV_SEL && !busy;
  assign cfg_ok = bidx_r == IDX_DATA && (write_latch ||
    shift_r == WL_SET || shift_r == WL_CLR);
  assign vt_ok = write_latch && prog_s && shift_r == VTRIP_DATA;
  assign arr_ok = write_latch && !prog_s && !lock_hit;
  assign data_ack = is_cfg ? cfg_ok : (vt_ok || arr_ok);
  assign ack_now = (bidx_r == 3'h0) ? adr_ack :
    (bidx_r < IDX_DATA) ? 1'b1 : data_ack;
  assign lock_refuse = byte_end && bidx_r >= IDX_DATA && !is_cfg &&
    write_latch && !prog_s && lock_hit;
  assign cfg_end = stop_ev && pend_reg_r && !abort_r;
  assign nv_wr = cfg_end && reg_write_unlock &&
    !rx_data_r[B_UNLOCK];
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = ~drive_r;
  assign arr_rd_addr = ptr_r[13:0];
  assign nv_word = {hw_protect_arm, dog_r, lock_r};
  assign lock_sel = lock_r;
  assign dog_period_sel = dog_r;
  assign dog_enable = dog_r != DOG_OFF;
  assign dog_timeout_ms = (dog_r == DOG_C0) ? DOG_MS_0 :
    (dog_r == DOG_C1) ? DOG_MS_1 : (dog_r == DOG_OFF) ? 11'h000 : DOG_MS_2;
  assign nv_busy = busy;

  ////////////////////////////////////////////////////////////////////////
  // configuration latches and stored bits
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      write_latch <= 1'b0;
      reg_write_unlock <= 1'b0;
      hw_protect_arm <= FACT_ARM;
      dog_r <= FACT_DOG;
      lock_r <= FACT_LOCK;
      boot_r <= 1'b0;
    end
    else if (!boot_r)
    begin
      {hw_protect_arm, dog_r, lock_r} <= nv_image;
      boot_r <= 1'b1;
    end
    else if (lock_refuse)
      reg_write_unlock <= 1'b0;
    else if (cfg_end && reg_write_unlock)
    begin
      write_latch <= rx_data_r[B_WLATCH];
      if (!rx_data_r[B_UNLOCK])
      begin
        reg_write_unlock <= 1'b0;
        dog_r <= {rx_data_r[B_DOG_HI], rx_data_r[B_DOG_LO]};
        if (!hw_protect)
        begin
          hw_protect_arm <= rx_data_r[B_ARM];
          lock_r <= {rx_data_r[B_LOCK2], rx_data_r[B_LOCK1],
            rx_data_r[B_LOCK0]};
        end
      end
    end
    else if (cfg_end)
    begin
      if (rx_data_r == WL_SET)
        write_latch <= 1'b1;
      else if (rx_data_r == UNLOCK_SET && write_latch)
        reg_write_unlock <= 1'b1;
      else if (rx_data_r == WL_CLR)
        write_latch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // busy timer and stop-time pulses
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_r <= '0;
      nv_store <= 1'b0;
      vtrip_prog <= 1'b0;
      scl_p <= 1'b0;
      sda_p <= 1'b0;
    end
    else
    begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      nv_store <= nv_wr;
      vtrip_prog <= stop_ev && pend_vt_r;
      if (stop_ev && (nv_wr || arr_done_r || pend_vt_r))
        busy_r <= BW'(NV_CYCLES);
      else if (busy)
        busy_r <= busy_r - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // byte engine
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dst_r <= D_IDLE;
      bitc_r <= 4'h0;
      bidx_r <= 3'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rx_data_r <= 8'h00;
      ptr_r <= 16'h0000;
      drive_r <= 1'b0;
      rd_mode_r <= 1'b0;
      pend_reg_r <= 1'b0;
      abort_r <= 1'b0;
      pend_vt_r <= 1'b0;
      arr_done_r <= 1'b0;
      arr_wr_en <= 1'b0;
      arr_wr_addr <= '0;
      arr_wr_data <= 8'h00;
    end
    else
    begin
      arr_wr_en <= 1'b0;
      if (start_ev || stop_ev)
      begin
        dst_r <= start_ev ? D_RECV : D_IDLE;
        bitc_r <= 4'h0;
        bidx_r <= 3'h0;
        drive_r <= 1'b0;
        pend_reg_r <= 1'b0;
        abort_r <= 1'b0;
        pend_vt_r <= 1'b0;
        arr_done_r <= 1'b0;
      end
      else
        case (dst_r)
          D_RECV:
            if (rise)
            begin
              shift_r <= {shift_r[6:0], sda_s};
              bitc_r <= bitc_r + 4'h1;
            end
            else if (byte_end)
            begin
              drive_r <= ack_now;
              dst_r <= (bidx_r == 3'h0 && !adr_ack) ? D_IDLE : D_ACK;
              if (bidx_r == 3'h0)
                rd_mode_r <= shift_r[0];
              if (bidx_r == IDX_HI)
                ptr_r[15:8] <= shift_r;
              if (bidx_r == IDX_LO)
                ptr_r[7:0] <= shift_r;
              if (bidx_r >= IDX_DATA && is_cfg)
              begin
                if (bidx_r == IDX_DATA)
                begin
                  pend_reg_r <= cfg_ok;
                  rx_data_r <= shift_r;
                end
                else
                  abort_r <= 1'b1;
              end
              else if (bidx_r >= IDX_DATA && vt_ok)
                pend_vt_r <= 1'b1;
              else if (bidx_r >= IDX_DATA && arr_ok)
              begin
                arr_wr_en <= 1'b1;
                arr_wr_addr <= ptr_r[13:0];
                arr_wr_data <= shift_r;
                ptr_r <= ptr_r + 16'h0001;
                arr_done_r <= 1'b1;
              end
            end
          D_ACK:
            if (fall)
            begin
              bitc_r <= 4'h0;
              bidx_r <= (bidx_r == IDX_MORE) ? IDX_MORE : bidx_r + 3'h1;
              if (rd_mode_r)
              begin
                tx_r <= tx_sel;
                drive_r <= ~tx_sel[7];
                dst_r <= D_SEND;
              end
              else
              begin
                drive_r <= 1'b0;
                dst_r <= D_RECV;
              end
            end
          D_SEND:
            if (fall && bitc_r == SEND_LAST)
            begin
              drive_r <= 1'b0;
              dst_r <= D_MACK;
            end
            else if (fall)
            begin
              bitc_r <= bitc_r + 4'h1;
              tx_r <= {tx_r[6:0], 1'b0};
              drive_r <= ~tx_r[6];
            end
          D_MACK:
            if (rise && !sda_s && !is_cfg)
            begin
              ptr_r <= ptr_r + 16'h0001;
              dst_r <= D_ACK;
            end
            else if (rise)
              dst_r <= D_IDLE;
          default: dst_r <= D_IDLE;
        endcase
    end
  end
endmodule
`default_nettype wire

// >>> logic/sup_host_end.sv
// bus-master end: runs write and random-read frames for software
`timescale 1ns/1ps
`default_nettype none
module sup_host_end (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // two-wire link
  sup_link_if.host link,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata
);
  import sup_pkg::*;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} suph_st_t;
  suph_st_t hst_r;
  logic [15:0] addr_r, data_r;
  logic [1:0] op_r, ph_r, np;
  logic [2:0] qcnt_r, bidx_r;
  logic [3:0] bitn_r;
  logic [7:0] tx_r, rx_r, rd_byte_r;
  logic nack_r, ack_r, scl_r, sda_r, sda_s, tick, rdat, is_rd, go;
  logic [2:0] last_idx;

  function automatic logic [7:0] byte_for(input logic [2:0] i,
    input logic [15:0] a, input logic [15:0] d, input logic rd);
    case (i)
      3'h0: byte_for = {DEV_SEL, 1'b0};
      IDX_HI: byte_for = a[15:8];
      IDX_LO: byte_for = a[7:0];
      IDX_DATA: byte_for = rd ? {DEV_SEL, 1'b1} : d[7:0];
      default: byte_for = d[15:8];
    endcase
  endfunction

  sup_sync2 #(.W(1)) u_sync (.clk(clk), .sys_rst(sys_rst),
    .async_in(link.sda), .sync_out(sda_s));

  assign tick = qcnt_r == 3'(QTR_CYC - 1);
  assign np = ph_r + 2'h1;
  assign is_rd = op_r == OP_RD;
  assign rdat = is_rd && bidx_r == IDX_MORE;
  assign last_idx = (op_r == OP_WR1) ? IDX_DATA : IDX_MORE;
  assign go = sw_wr && sw_addr == HR_CMD && hst_r == H_IDLE &&
    sw_wdata[1:0] != 2'h0;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe_n = scl_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = sda_r;

  ////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_r <= 16'h0000;
      data_r <= 16'h0000;
      sw_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (sw_wr && sw_addr == HR_ADDR)
        addr_r <= sw_wdata[15:0];
      if (sw_wr && sw_addr == HR_DATA)
        data_r <= sw_wdata[15:0];
      if (sw_rd)
        case (sw_addr)
          HR_ADDR: sw_rdata <= {16'h0000, addr_r};
          HR_DATA: sw_rdata <= {16'h0000, data_r};
          HR_STAT: sw_rdata <= {16'h0000, rd_byte_r, 6'h00, nack_r,
            hst_r != H_IDLE};
          default: sw_rdata <= 32'h0000_0000;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame sequencer; every symbol is four quarter phases, scl low first
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hst_r <= H_IDLE;
      op_r <= 2'h0;
      ph_r <= 2'h0;
      qcnt_r <= 3'h0;
      bidx_r <= 3'h0;
      bitn_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rd_byte_r <= 8'h00;
      nack_r <= 1'b0;
      ack_r <= 1'b0;
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end
    else if (hst_r == H_IDLE)
    begin
      qcnt_r <= 3'h0;
      ph_r <= 2'h0;
      if (go)
      begin
        op_r <= sw_wdata[1:0];
        nack_r <= 1'b0;
        bidx_r <= 3'h0;
        scl_r <= 1'b0;
        hst_r <= H_START;
      end
    end
    else
    begin
      qcnt_r <= tick ? 3'h0 : qcnt_r + 3'h1;
      if (tick)
      begin
        ph_r <= np;
        if (np != 2'h0)
          scl_r <= np[1];
        case (hst_r)
          H_START: sda_r <= (np == 2'h0) ? sda_r : (np != 2'h3);
          H_BYTE: sda_r <= (np == 2'h0) ? sda_r :
            (bitn_r == BYTE_BITS || rdat) ? 1'b1 : tx_r[7];
          default: sda_r <= (np == 2'h0) ? sda_r : (np == 2'h3);
        endcase
        if (hst_r == H_BYTE && ph_r == 2'h2)
        begin
          if (bitn_r == BYTE_BITS)
            ack_r <= sda_s;
          else
            rx_r <= {rx_r[6:0], sda_s};
        end
        if (ph_r == 2'h3)
        begin
          scl_r <= 1'b0;
          case (hst_r)
            H_START:
            begin
              hst_r <= H_BYTE;
              bitn_r <= 4'h0;
              tx_r <= byte_for(bidx_r, addr_r, data_r, is_rd);
            end
            H_BYTE:
              if (bitn_r != BYTE_BITS)
              begin
                bitn_r <= bitn_r + 4'h1;
                tx_r <= {tx_r[6:0], 1'b0};
              end
              else if (ack_r && !rdat)
              begin
                nack_r <= 1'b1;
                hst_r <= H_STOP;
              end
              else if (rdat || bidx_r == last_idx)
              begin
                if (rdat)
                  rd_byte_r <= rx_r;
                hst_r <= H_STOP;
              end
              else if (is_rd && bidx_r == IDX_LO)
              begin
                bidx_r <= IDX_DATA;
                hst_r <= H_START;
              end
              else
              begin
                bidx_r <= bidx_r + 3'h1;
                bitn_r <= 4'h0;
                tx_r <= byte_for(bidx_r + 3'h1, addr_r, data_r, is_rd);
              end
            default:
            begin
              scl_r <= 1'b1;
              hst_r <= H_IDLE;
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> logic/sup_link_if.sv
// two-wire link between controller and supervisor device
`timescale 1ns/1ps
`default_nettype none
interface sup_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // open-drain wires: a driver pulls low, pull-up otherwise
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o,
    output host_scl_oe_n, output host_sda_o, output host_sda_oe_n);
endinterface
`default_nettype wire

// >>> logic/sup_pkg.sv
// shared constants for the supervisor two-wire link ends
package sup_pkg;
  localparam logic [15:0] CFG_ADDR = 16'hffff;
  // device select code, value is arbitrary
  localparam logic [6:0] DEV_SEL = 7'h57;
  localparam int ARR_AW = 14;
  localparam int NV_W = 6;
  // configuration byte layout
  localparam int B_ARM = 7;
  localparam int B_DOG_HI = 6;
  localparam int B_DOG_LO = 5;
  localparam int B_LOCK1 = 4;
  localparam int B_LOCK0 = 3;
  localparam int B_UNLOCK = 2;
  localparam int B_WLATCH = 1;
  localparam int B_LOCK2 = 0;
  localparam logic [7:0] WL_SET = 8'h02;
  localparam logic [7:0] UNLOCK_SET = 8'h06;
  localparam logic [7:0] WL_CLR = 8'h00;
  localparam logic [7:0] VTRIP_DATA = 8'h00;
  // factory values of the stored bits
  localparam logic [1:0] FACT_DOG = 2'h3;
  localparam logic [2:0] FACT_LOCK = 3'h0;
  localparam logic FACT_ARM = 1'h0;
  // lock select codes and range limits
  localparam logic [2:0] LK_Q4 = 3'h1;
  localparam logic [2:0] LK_HALF = 3'h2;
  localparam logic [2:0] LK_ALL = 3'h3;
  localparam logic [2:0] LK_P1 = 3'h4;
  localparam logic [2:0] LK_P2 = 3'h5;
  localparam logic [2:0] LK_P4 = 3'h6;
  localparam logic [2:0] LK_P8 = 3'h7;
  localparam logic [13:0] Q4_BASE = 14'h3000;
  localparam logic [13:0] HALF_BASE = 14'h2000;
  localparam logic [13:0] P1_TOP = 14'h003f;
  localparam logic [13:0] P2_TOP = 14'h007f;
  localparam logic [13:0] P4_TOP = 14'h00ff;
  localparam logic [13:0] P8_TOP = 14'h01ff;
  // watchdog period codes, timeouts in ms
  localparam logic [1:0] DOG_C0 = 2'h0;
  localparam logic [1:0] DOG_C1 = 2'h1;
  localparam logic [1:0] DOG_OFF = 2'h3;
  localparam logic [10:0] DOG_MS_0 = 11'h578;
  localparam logic [10:0] DOG_MS_1 = 11'h258;
  localparam logic [10:0] DOG_MS_2 = 11'h0c8;
  // byte framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] SEND_LAST = 4'h7;
  localparam logic [2:0] IDX_HI = 3'h1;
  localparam logic [2:0] IDX_LO = 3'h2;
  localparam logic [2:0] IDX_DATA = 3'h3;
  localparam logic [2:0] IDX_MORE = 3'h4;
  // timing
  localparam int CLK_KHZ = 125000;
  localparam int CLK_NS = 8;
  localparam int NV_WRITE_MS = 10;
  localparam int NV_CYC_DEF = NV_WRITE_MS * CLK_KHZ;
  localparam int LINK_NS = 160;
  localparam int QTR_CYC = LINK_NS / (4 * CLK_NS);
  // controller register map and commands
  localparam logic [3:0] HR_ADDR = 4'h0;
  localparam logic [3:0] HR_DATA = 4'h4;
  localparam logic [3:0] HR_CMD = 4'h8;
  localparam logic [3:0] HR_STAT = 4'hc;
  localparam logic [1:0] OP_WR1 = 2'h1;
  localparam logic [1:0] OP_WR2 = 2'h2;
  localparam logic [1:0] OP_RD = 2'h3;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_RDAT = 8;
endpackage

// >>> logic/sup_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sup_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> tb/sup_link_checker.sv
// wire-level checks on the supervisor two-wire link
`timescale 1ns/1ps
`default_nettype none
module sup_link_checker (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link drivers and resolved wires
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence scl_low_phase;
    !scl [*8] ##[1:4] scl;
  endsequence
  sequence scl_high_phase;
    scl [*8];
  endsequence
  host_hold_high_a: assert property (
    $rose(scl) |=> $stable(host_sda_oe_n) [*4])
    else $error("host moved data early in clock high");
  dev_quiet_start_a: assert property (
    $fell(sda) && scl && $past(scl) |=> dev_sda_oe_n [*8])
    else $error("device drives data line after start");
  dev_quiet_stop_a: assert property (
    $rose(sda) && scl && $past(scl) |=> dev_sda_oe_n [*8])
    else $error("device drives data line after stop");
  scl_low_len_a: assert property ($fell(scl) |-> scl_low_phase)
    else $error("clock low phase of wrong length");
  scl_high_len_a: assert property ($rose(scl) |-> scl_high_phase)
    else $error("clock high phase too short");
  dev_change_low_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device moved data while clock high");
  dev_hold_high_a: assert property (
    $rose(scl) |=> $stable(dev_sda_oe_n) [*8])
    else $error("device data not held through clock high");
  dev_release_a: assert property (
    !dev_sda_oe_n |-> ##[0:250] dev_sda_oe_n)
    else $error("device holds data line too long");
  dev_drive_c: cover property (!dev_sda_oe_n && scl && !sda);
endmodule
`default_nettype wire

// >>> tb/supervisor_ctrl_reg_write_protect_test.sv
// testbench: software port drives the host end against the device end
`timescale 1ns/1ps
`default_nettype none
module supervisor_ctrl_reg_write_protect_test;
  import sup_pkg::*;
  typedef struct {
    logic [1:0] op; logic [15:0] addr; logic [15:0] data;
    logic wp; logic pg; logic nk; logic [7:0] rd;
  } sup_row_t;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'h0;
  logic sw_rd = 1'h0;
  logic [31:0] sw_rdata;
  logic wp_pin = 1'h0;
  logic wp_prog_level = 1'h0;
  logic [5:0] nv_image = 6'h18;
  logic nv_store, arr_wr_en, dog_enable, hw_protect, nv_busy, vtrip_prog;
  logic [5:0] nv_word;
  logic [13:0] arr_wr_addr, arr_rd_addr, last_wa;
  logic [7:0] arr_wr_data, arr_rd_data, last_wd, rd;
  logic [1:0] dog_period_sel;
  logic [10:0] dog_timeout_ms;
  logic [2:0] lock_sel;
  logic nk;
  int miscompares = 0;
  int n_compared = 0;
  int n_store = 0;
  int n_arr = 0;
  int n_vt = 0;
  sup_row_t rows [0:27] = '{
    '{OP_RD, 16'hffff, 16'h00, 1'h0, 1'h0, 1'h0, 8'h60},
    '{OP_WR1, 16'h0010, 16'h55, 1'h0, 1'h0, 1'h1, 8'h00},
    '{OP_WR1, 16'hffff, 16'h02, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h06, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_RD, 16'hffff, 16'h00, 1'h0, 1'h0, 1'h0, 8'h66},
    '{OP_WR1, 16'hffff, 16'h23, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h02, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h06, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h06, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_RD, 16'hffff, 16'h00, 1'h0, 1'h0, 1'h0, 8'h27},
    '{OP_WR2, 16'hffff, 16'h0303, 1'h0, 1'h0, 1'h1, 8'h00},
    '{OP_WR1, 16'h0020, 16'h11, 1'h0, 1'h0, 1'h1, 8'h00},
    '{OP_WR1, 16'h0040, 16'h22, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_RD, 16'hffff, 16'h00, 1'h0, 1'h0, 1'h0, 8'h23},
    '{OP_WR1, 16'hffff, 16'h06, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'ha3, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h02, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h06, 1'h1, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h0a, 1'h1, 1'h0, 1'hx, 8'h00},
    '{OP_RD, 16'hffff, 16'h00, 1'h1, 1'h0, 1'h0, 8'h83},
    '{OP_WR1, 16'h0100, 16'h00, 1'h1, 1'h1, 1'h0, 8'h00},
    '{OP_WR1, 16'h0100, 16'h00, 1'h1, 1'h1, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h02, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'h06, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'hffff, 16'hca, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_WR1, 16'h3000, 16'h33, 1'h0, 1'h0, 1'h1, 8'h00},
    '{OP_WR1, 16'h2fff, 16'h44, 1'h0, 1'h0, 1'h0, 8'h00},
    '{OP_RD, 16'h0040, 16'h00, 1'h1, 1'h0, 1'h0, 8'h1a}
  };
  ////////////////////////////////////////////////////////////////////////////
  sup_link_if sup_link_if_inst ();
  sup_host_end sup_host_end_inst (.clk(clk), .sys_rst(sys_rst),
    .link(sup_link_if_inst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  sup_dev_end #(.NV_CYCLES(50)) sup_dev_end_inst (.clk(clk),
    .sys_rst(sys_rst), .link(sup_link_if_inst), .wp_pin(wp_pin),
    .wp_prog_level(wp_prog_level), .nv_image(nv_image),
    .nv_store(nv_store), .nv_word(nv_word), .arr_wr_en(arr_wr_en),
    .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data),
    .arr_rd_addr(arr_rd_addr), .arr_rd_data(arr_rd_data),
    .dog_period_sel(dog_period_sel), .dog_enable(dog_enable),
    .dog_timeout_ms(dog_timeout_ms), .lock_sel(lock_sel),
    .hw_protect(hw_protect), .nv_busy(nv_busy), .vtrip_prog(vtrip_prog));
  sup_link_checker sup_link_checker_inst (.clk(clk), .sys_rst(sys_rst),
    .host_scl_o(sup_link_if_inst.host_scl_o),
    .host_scl_oe_n(sup_link_if_inst.host_scl_oe_n),
    .host_sda_o(sup_link_if_inst.host_sda_o),
    .host_sda_oe_n(sup_link_if_inst.host_sda_oe_n),
    .dev_sda_o(sup_link_if_inst.dev_sda_o),
    .dev_sda_oe_n(sup_link_if_inst.dev_sda_oe_n),
    .scl(sup_link_if_inst.scl), .sda(sup_link_if_inst.sda));
  assign arr_rd_data = arr_rd_addr[7:0] ^ 8'h5a;
  always #4 clk = ~clk;
  // stored bits survive reset like the real nonvolatile cells
  always @(posedge clk)
  begin
    if (nv_store === 1'h1) nv_image <= nv_word;
    if (nv_store === 1'h1) n_store++;
    if (vtrip_prog === 1'h1) n_vt++;
    if (arr_wr_en === 1'h1) n_arr++;
    if (arr_wr_en === 1'h1) last_wa <= arr_wr_addr;
    if (arr_wr_en === 1'h1) last_wd <= arr_wr_data;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] e,
    input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'h1;
    @(posedge clk);
    sw_wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge clk);
    sw_rd <= 1'h0;
    @(posedge clk);
    d = sw_rdata;
  endtask
  task automatic run(input sup_row_t r, output logic k, output logic [7:0] v);
    logic [31:0] st;
    int n;
    n = 0;
    wp_pin <= r.wp;
    wp_prog_level <= r.pg;
    // pin synchronisers settle
    repeat (4) @(posedge clk);
    while (nv_busy !== 1'h0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    sw_write(HR_ADDR, {16'h0, r.addr});
    sw_write(HR_DATA, {16'h0, r.data});
    sw_write(HR_CMD, {30'h0, r.op});
    st = 32'h1;
    while (st[ST_BUSY] !== 1'h0 && n < 5000)
    begin
      sw_read(HR_STAT, st);
      n++;
    end
    if (n >= 5000)
    begin
      miscompares++;
      $display("wrong value timeout expected idle seen busy");
      conclude();
    end
    k = st[ST_NACK];
    v = st[ST_RDAT +: 8];
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk);
    cmp("dog on", {15'h0, dog_enable}, 16'h0);
    foreach (rows[i])
    begin
      run(rows[i], nk, rd);
      if (rows[i].nk !== 1'hx)
        cmp("ack", {15'h0, rows[i].nk}, {15'h0, nk});
      if (rows[i].op == OP_RD)
        cmp("reg", {8'h0, rows[i].rd}, {8'h0, rd});
    end
    repeat (4) @(posedge clk);
    cmp("lock", {13'h0, lock_sel}, 16'h1);
    cmp("period", {14'h0, dog_period_sel}, 16'h2);
    cmp("timeout", {5'h0, dog_timeout_ms}, {5'h0, DOG_MS_2});
    cmp("dog on end", {15'h0, dog_enable}, 16'h1);
    cmp("protect", {15'h0, hw_protect}, 16'h1);
    cmp("vtrip", n_vt[15:0], 16'h2);
    cmp("arr count", n_arr[15:0], 16'h2);
    cmp("arr addr", {2'h0, last_wa}, 16'h2fff);
    cmp("arr data", {8'h0, last_wd}, 16'h44);
    cmp("stores", n_store[15:0], 16'h4);
    wp_pin <= 1'h0;
    wp_prog_level <= 1'h0;
    repeat (4) @(posedge clk);
    cmp("protect off", {15'h0, hw_protect}, 16'h0);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    run(rows[0], nk, rd);
    cmp("after reset", {8'h0, rd}, 16'hc8);
    conclude();
  end
endmodule
`default_nettype wire
